// *** rtl/glfh_pkg.sv ***
// Package for the ground-loss fault handler: regulator indices, states,
// synchroniser depth and error counter width.
// Assumes one 100 MHz system clock shared by every user of this package.
package glfh_pkg;

   // ----------------------------------------------------------------------
   // Regulator indices
   // ----------------------------------------------------------------------
   localparam int NUM_REG      = 3;
   localparam int IDX_WIDE     = 0;
   localparam int IDX_LV       = 1;
   localparam int IDX_STEPUP   = 2;

   // ----------------------------------------------------------------------
   // Counter and reset values
   // ----------------------------------------------------------------------
   localparam int          ERR_CNT_W   = 4;
   localparam logic [3:0]  ERR_CNT_RST = 4'h0;
   localparam logic [3:0]  ERR_CNT_MAX = 4'hF;
   localparam logic [2:0]  FLAG_RST    = 3'h0;
   localparam logic [2:0]  EN_RST      = 3'h0;
   localparam int          SYNC_STAGES = 2;

   // ----------------------------------------------------------------------
   // Device states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      GLFH_ACTIVE,
      GLFH_SAFE,
      GLFH_OFF,
      GLFH_RESET
   } glfh_state_t;

endpackage : glfh_pkg

// *** rtl/glfh_sync.sv ***
// Two-flop synchroniser, one per ground-loss comparator bit.
// Assumes inputs may change at any time relative to mclk_in.
`timescale 1ns/100ps
module glfh_sync (
   input  wire logic       mclk_in,
   input  wire logic       reset_in,
   input  wire logic [2:0] async_in,
   output logic      [2:0] sync_out
);
   logic [2:0] stage1_reg;
   logic [2:0] stage1_next;
   logic [2:0] stage2_reg;
   logic [2:0] stage2_next;

   always_comb begin
      stage1_next = async_in;
      stage2_next = stage1_reg;
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         stage1_reg <= glfh_pkg::FLAG_RST;
         stage2_reg <= glfh_pkg::FLAG_RST;
      end else begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
      end
   end

   assign sync_out = stage2_reg;
endmodule : glfh_sync

// *** rtl/glfh_top.sv ***
// Ground-loss fault handler for the wide-input step-down, low-voltage
// step-down and step-up regulators: gating, enables, flags, state,
// error counter and the interrupt pin.
// Assumes analog comparators already apply both ground-loss thresholds
// and that control bits arrive as plain synchronous levels.
//
// Summary of operation
// - Ground loss disables regulator, blocks re-enable.
// - Wide loss, off-enable 1: all off, discharge.
// - Same case: flag, OFF state, analog latch.
// - Wide loss, off-enable 0: all off, flag.
// - Same case: clear enables, enter SAFE.
// - Error counter counts SAFE-mode losses.
// - Same losses drive interrupt pin low.
// - Software sets an undervoltage as reset condition.
// - In RESET, wide regulator re-enables when clean.
// - LV loss: off, clear enable, flag, SAFE.
// - LV reset-enable 1: RESET on undervoltage.
// - LV reset-enable 0: keep state, retry allowed.
// - Step-up loss: off, clear enable, flag.
// - Step-up reset-enable 1: RESET on undervoltage.
// - Step-up reset-enable 0: keep state, retry.
`timescale 1ns/100ps
module glfh_top (
   input  wire logic       mclk_in,
   input  wire logic       reset_in,
   input  wire logic [2:0] gndloss_detect_in,
   input  wire logic       wide_stepdown_gndloss_off_enable_in,
   input  wire logic       lv_stepdown_undervolt_reset_enable_in,
   input  wire logic       stepup_undervolt_reset_enable_in,
   input  wire logic       wide_stepdown_undervolt_reset_enable_in,
   input  wire logic [2:0] undervolt_in,
   input  wire logic       lv_stepdown_enable_set_in,
   input  wire logic       stepup_enable_set_in,
   input  wire logic [2:0] flag_clear_in,
   input  wire logic       irq_clear_in,
   input  wire logic       reset_exit_in,
   input  wire logic       safe_exit_in,
   output logic            wide_stepdown_gndloss_flag_out,
   output logic            lv_stepdown_gndloss_flag_out,
   output logic            stepup_gndloss_flag_out,
   output logic            lv_stepdown_enable_out,
   output logic            stepup_enable_out,
   output logic      [2:0] regulator_on_out,
   output logic      [2:0] discharge_out,
   output logic            analog_latch_out,
   output logic      [3:0] error_count_out,
   output logic      [1:0] device_state_out,
   output logic            driver_enable_interrupt_n_out
);
   localparam int W = glfh_pkg::IDX_WIDE;
   localparam int L = glfh_pkg::IDX_LV;
   localparam int S = glfh_pkg::IDX_STEPUP;

   // ----------------------------------------------------------------------
   // Synchronised detectors
   // ----------------------------------------------------------------------
   logic [2:0] loss;
   logic [2:0] loss_prev_reg;
   logic [2:0] loss_prev_next;
   logic [2:0] loss_rise;

   glfh_sync u_sync (
      .mclk_in  (mclk_in),
      .reset_in (reset_in),
      .async_in (gndloss_detect_in),
      .sync_out (loss)
   );

   assign loss_rise = loss & ~loss_prev_reg;

   // ----------------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------------
   glfh_pkg::glfh_state_t state_reg;
   glfh_pkg::glfh_state_t state_next;
   logic [2:0] flag_reg;
   logic [2:0] flag_next;
   logic [2:0] en_reg;
   logic [2:0] en_next;
   logic [2:0] dis_reg;
   logic [2:0] dis_next;
   logic       alatch_reg;
   logic       alatch_next;
   logic [3:0] err_reg;
   logic [3:0] err_next;
   logic       irq_reg;
   logic       irq_next;
   logic       count_evt;
   logic       wide_off;
   logic       wide_safe;
   logic       uv_req;

   // The wide regulator enable is owned by this block: it drops on loss
   // and comes back in RESET or ACTIVE once clean, so software cannot force it on.
   always_comb begin
      loss_prev_next = loss;
      state_next     = state_reg;
      flag_next      = flag_reg;
      en_next        = en_reg;
      dis_next       = dis_reg;
      alatch_next    = alatch_reg;
      err_next       = err_reg;
      irq_next       = irq_reg;
      wide_off       = loss_rise[W] & wide_stepdown_gndloss_off_enable_in;
      wide_safe      = loss_rise[W] & ~wide_stepdown_gndloss_off_enable_in;
      count_evt      = wide_safe | loss_rise[L];

      // Software retries, refused while the loss persists.
      if (lv_stepdown_enable_set_in && !loss[L]) begin
         en_next[L] = 1'b1;
      end
      if (stepup_enable_set_in && !loss[S]) begin
         en_next[S] = 1'b1;
      end

      // Flag clear is refused while detected; a new set wins.
      for (int i = 0; i < glfh_pkg::NUM_REG; i++) begin
         if (flag_clear_in[i] && !loss[i]) begin
            flag_next[i] = 1'b0;
         end
         if (loss_rise[i]) begin
            flag_next[i] = 1'b1;
         end
         if (loss[i]) begin
            en_next[i] = 1'b0;
         end
      end

      if (irq_clear_in) begin
         irq_next = 1'b0;
      end
      if (count_evt) begin
         irq_next = 1'b1;
         if (err_reg != glfh_pkg::ERR_CNT_MAX) begin
            err_next = err_reg + 4'h1;
         end
      end

      if (loss_rise[S]) begin
         en_next[S] = 1'b0;
      end
      if (loss_rise[L]) begin
         en_next[L]  = 1'b0;
         dis_next[L] = 1'b0;
         state_next  = glfh_pkg::GLFH_SAFE;
      end
      if (wide_safe) begin
         en_next    = glfh_pkg::EN_RST;
         dis_next   = glfh_pkg::EN_RST;
         state_next = glfh_pkg::GLFH_SAFE;
      end
      if (wide_off) begin
         en_next     = glfh_pkg::EN_RST;
         dis_next    = 3'h7;
         alatch_next = 1'b1;
         state_next  = glfh_pkg::GLFH_OFF;
      end

      // Undervoltage reset decisions; the reset-enable bits decide whether
      // a discharged rail pulls the device into RESET or leaves it alone.
      uv_req = (lv_stepdown_undervolt_reset_enable_in && undervolt_in[L]) ||
               (stepup_undervolt_reset_enable_in && undervolt_in[S]) ||
               (wide_stepdown_undervolt_reset_enable_in && undervolt_in[W]);
      if (!loss_rise[W] && state_reg != glfh_pkg::GLFH_OFF && uv_req) begin
         state_next = glfh_pkg::GLFH_RESET;
      end

      case (state_reg)
         glfh_pkg::GLFH_RESET: begin
            if (!loss[W]) begin
               en_next[W]  = 1'b1;
               dis_next[W] = 1'b0;
               // A pending undervoltage keeps the device in RESET.
               if (reset_exit_in && !loss_rise[L] && !uv_req) begin
                  state_next = glfh_pkg::GLFH_ACTIVE;
               end
            end
         end
         glfh_pkg::GLFH_SAFE: begin
            if (safe_exit_in && state_next == glfh_pkg::GLFH_SAFE
                && !count_evt) begin
               state_next = glfh_pkg::GLFH_ACTIVE;
            end
         end
         glfh_pkg::GLFH_ACTIVE: begin
            if (!en_reg[W] && !loss[W] && !wide_off && !wide_safe) begin
               en_next[W] = 1'b1;
            end
         end
         glfh_pkg::GLFH_OFF: begin
            en_next = glfh_pkg::EN_RST;
         end
         default: begin
            state_next = glfh_pkg::GLFH_OFF;
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         loss_prev_reg <= glfh_pkg::FLAG_RST;
         state_reg     <= glfh_pkg::GLFH_RESET;
         flag_reg      <= glfh_pkg::FLAG_RST;
         en_reg        <= glfh_pkg::EN_RST;
         dis_reg       <= glfh_pkg::EN_RST;
         alatch_reg    <= 1'b0;
         err_reg       <= glfh_pkg::ERR_CNT_RST;
         irq_reg       <= 1'b0;
      end else begin
         loss_prev_reg <= loss_prev_next;
         state_reg     <= state_next;
         flag_reg      <= flag_next;
         en_reg        <= en_next;
         dis_reg       <= dis_next;
         alatch_reg    <= alatch_next;
         err_reg       <= err_next;
         irq_reg       <= irq_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign wide_stepdown_gndloss_flag_out = flag_reg[W];
   assign lv_stepdown_gndloss_flag_out   = flag_reg[L];
   assign stepup_gndloss_flag_out        = flag_reg[S];
   assign lv_stepdown_enable_out         = en_reg[L];
   assign stepup_enable_out              = en_reg[S];
   assign regulator_on_out               = en_reg & ~loss;
   assign discharge_out                  = dis_reg;
   assign analog_latch_out               = alatch_reg;
   assign error_count_out                = err_reg;
   assign device_state_out               = state_reg;
   assign driver_enable_interrupt_n_out  = ~irq_reg;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence s_wide_off_evt;
      loss_rise[W] && wide_stepdown_gndloss_off_enable_in;
   endsequence

   property p_no_on_in_loss;
      @(posedge mclk_in) disable iff (reset_in)
      loss != 3'h0 |=> (en_reg & $past(loss)) == 3'h0;
   endproperty
   a_no_on_in_loss: assert property (p_no_on_in_loss)
      else $error("regulator enabled during ground loss");

   property p_wide_off;
      @(posedge mclk_in) disable iff (reset_in)
      s_wide_off_evt |=> discharge_out == 3'h7 && en_reg == 3'h0
         && analog_latch_out && state_reg == glfh_pkg::GLFH_OFF;
   endproperty
   a_wide_off: assert property (p_wide_off)
      else $error("wide loss off handling wrong");

   property p_wide_safe;
      @(posedge mclk_in) disable iff (reset_in)
      loss_rise[W] && !wide_stepdown_gndloss_off_enable_in |=>
         state_reg == glfh_pkg::GLFH_SAFE && discharge_out == 3'h0
         && !lv_stepdown_enable_out && !stepup_enable_out
         && wide_stepdown_gndloss_flag_out;
   endproperty
   a_wide_safe: assert property (p_wide_safe)
      else $error("wide loss safe handling wrong");

   property p_err_inc;
      @(posedge mclk_in) disable iff (reset_in)
      count_evt && err_reg != glfh_pkg::ERR_CNT_MAX |=>
         err_reg == $past(err_reg) + 4'h1;
   endproperty
   a_err_inc: assert property (p_err_inc)
      else $error("error counter did not increment");

   property p_irq;
      @(posedge mclk_in) disable iff (reset_in)
      count_evt |=> !driver_enable_interrupt_n_out;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not driven low");

   property p_reset_reenable;
      @(posedge mclk_in) disable iff (reset_in)
      state_reg == glfh_pkg::GLFH_RESET && !loss[W] |=> en_reg[W];
   endproperty
   a_reset_reenable: assert property (p_reset_reenable)
      else $error("wide regulator not re-enabled in reset");

   property p_lv_loss;
      @(posedge mclk_in) disable iff (reset_in)
      loss_rise[L] && !wide_off |=> !lv_stepdown_enable_out
         && lv_stepdown_gndloss_flag_out && !discharge_out[L];
   endproperty
   a_lv_loss: assert property (p_lv_loss)
      else $error("lv loss handling wrong");

   property p_uv_reset;
      @(posedge mclk_in) disable iff (reset_in)
      !loss_rise[W] && state_reg != glfh_pkg::GLFH_OFF
         && lv_stepdown_undervolt_reset_enable_in && undervolt_in[L]
         |=> state_reg == glfh_pkg::GLFH_RESET;
   endproperty
   a_uv_reset: assert property (p_uv_reset)
      else $error("lv undervoltage reset missed");

   property p_stepup_loss;
      @(posedge mclk_in) disable iff (reset_in)
      loss_rise[S] |=> !stepup_enable_out && stepup_gndloss_flag_out;
   endproperty
   a_stepup_loss: assert property (p_stepup_loss)
      else $error("step-up loss handling wrong");

   property p_flag_hold;
      @(posedge mclk_in) disable iff (reset_in)
      flag_reg[W] && loss[W] |=> flag_reg[W];
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("flag cleared while loss detected");
endmodule : glfh_top

// *** test/glfh_mcu_model.sv ***
// Behavioural system controller on the far side of the fault handler.
// Assumes it shares mclk_in and reset_in with the handler.
`timescale 1ns/100ps
module glfh_mcu_model #(
   parameter int ACK_DELAY = 10
) (
   input  wire logic mclk_in,
   input  wire logic reset_in,
   input  wire logic irq_n_in,
   input  wire logic retry_in,
   output logic      irq_clear_out,
   output logic      lv_enable_set_out,
   output logic      stepup_enable_set_out
);
   logic [7:0] wait_reg;
   logic       retry_reg;

   // Firmware polls slowly, so the pin is left low for a while first.
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         wait_reg  <= 8'h00;
         retry_reg <= 1'b0;
      end else begin
         wait_reg  <= (irq_n_in === 1'b0) ? wait_reg + 8'h01 : 8'h00;
         retry_reg <= retry_in;
      end
   end

   assign irq_clear_out         = (wait_reg == 8'(ACK_DELAY));
   assign lv_enable_set_out     = retry_reg;
   assign stepup_enable_set_out = retry_reg;
endmodule : glfh_mcu_model

// *** test/tb_ground_loss_fault_handler.sv ***
// Self-checking bench for the ground-loss fault handler.
// Assumes the controller model above services the interrupt pin.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
   err_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_ground_loss_fault_handler;
   logic       mclk_in = 1'b0;
   logic       reset_in = 1'b1;
   logic [2:0] det, uv, fclr, on, dis;
   logic       off_en, lv_rst, su_rst, wu_rst, rexit, sexit, retry;
   logic       wf, lf, sf, lv_en, su_en, latch, irq_n;
   logic       irq_clr, lv_set, su_set;
   logic [3:0] cnt, exp_cnt;
   logic [1:0] st;
   int         err_count = 0;
   int         compares = 0;

   always #5 mclk_in = ~mclk_in;

   glfh_top DUT (
      .mclk_in(mclk_in), .reset_in(reset_in), .gndloss_detect_in(det),
      .wide_stepdown_gndloss_off_enable_in(off_en),
      .lv_stepdown_undervolt_reset_enable_in(lv_rst),
      .stepup_undervolt_reset_enable_in(su_rst),
      .wide_stepdown_undervolt_reset_enable_in(wu_rst),
      .undervolt_in(uv), .lv_stepdown_enable_set_in(lv_set),
      .stepup_enable_set_in(su_set), .flag_clear_in(fclr),
      .irq_clear_in(irq_clr), .reset_exit_in(rexit),
      .safe_exit_in(sexit), .wide_stepdown_gndloss_flag_out(wf),
      .lv_stepdown_gndloss_flag_out(lf), .stepup_gndloss_flag_out(sf),
      .lv_stepdown_enable_out(lv_en), .stepup_enable_out(su_en),
      .regulator_on_out(on), .discharge_out(dis),
      .analog_latch_out(latch), .error_count_out(cnt),
      .device_state_out(st), .driver_enable_interrupt_n_out(irq_n));

   glfh_mcu_model MCU (
      .mclk_in(mclk_in), .reset_in(reset_in), .irq_n_in(irq_n),
      .retry_in(retry), .irq_clear_out(irq_clr),
      .lv_enable_set_out(lv_set), .stepup_enable_set_out(su_set));

   // -----------------------------------------------------------------
   // Access tasks
   // -----------------------------------------------------------------
   task look(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask : look

   // Bits are {flag clears, retry, safe exit, reset exit}.
   task strobe(input logic [5:0] m);
      @(posedge mclk_in);
      {fclr, retry, sexit, rexit} <= m;
      @(posedge mclk_in);
      {fclr, retry, sexit, rexit} <= 6'h00;
      look(3);
   endtask : strobe

   // Comparator edges need two sync stages plus one register stage.
   task loss(input logic [2:0] d);
      @(posedge mclk_in);
      det <= d;
      look(5);
   endtask : loss

   task end_of_test;
      if (err_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test

   initial begin
      #200000;
      err_count++;
      end_of_test;
   end

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   initial begin
      det = 3'h0; uv = 3'h0; fclr = 3'h0; off_en = 1'b0; lv_rst = 1'b0;
      su_rst = 1'b0; wu_rst = 1'b0; rexit = 1'b0; sexit = 1'b0;
      retry = 1'b0; exp_cnt = 4'h0;
      look(5);
      `CHK("state", 2'(glfh_pkg::GLFH_RESET), st)
      `CHK("irq", 1'b1, irq_n)
      `CHK("flags", 3'h0, {sf, lf, wf})
      @(posedge mclk_in);
      reset_in <= 1'b0;
      look(3);
      `CHK("wide on", 1'b1, on[0])
      strobe(6'h01);
      `CHK("state", 2'(glfh_pkg::GLFH_ACTIVE), st)
      strobe(6'h04);
      `CHK("on", 3'h7, on)
      // Low-voltage loss, retry and clear refused while it lasts.
      loss(3'h2);
      exp_cnt++;
      `CHK("lv flag", 1'b1, lf)
      `CHK("lv en", 1'b0, lv_en)
      `CHK("on", 3'h5, on)
      `CHK("dis", 3'h0, dis)
      `CHK("state", 2'(glfh_pkg::GLFH_SAFE), st)
      `CHK("count", exp_cnt, cnt)
      `CHK("irq", 1'b0, irq_n)
      strobe(6'h04);
      `CHK("lv en", 1'b0, lv_en)
      strobe(6'h10);
      `CHK("lv flag", 1'b1, lf)
      look(10);
      `CHK("irq", 1'b1, irq_n)
      loss(3'h0);
      `CHK("lv flag", 1'b1, lf)
      strobe(6'h10);
      `CHK("lv flag", 1'b0, lf)
      strobe(6'h04);
      `CHK("lv en", 1'b1, lv_en)
      `CHK("state", 2'(glfh_pkg::GLFH_SAFE), st)
      strobe(6'h02);
      `CHK("state", 2'(glfh_pkg::GLFH_ACTIVE), st)
      // Low-voltage loss with undervoltage reset enabled.
      @(posedge mclk_in);
      lv_rst <= 1'b1;
      loss(3'h2);
      exp_cnt++;
      @(posedge mclk_in);
      uv <= 3'h2;
      look(3);
      `CHK("state", 2'(glfh_pkg::GLFH_RESET), st)
      `CHK("count", exp_cnt, cnt)
      @(posedge mclk_in);
      uv <= 3'h0;
      lv_rst <= 1'b0;
      loss(3'h0);
      strobe(6'h01);
      strobe(6'h04);
      // Step-up loss keeps state, no count, no interrupt.
      loss(3'h4);
      `CHK("su en", 1'b0, su_en)
      `CHK("su flag", 1'b1, sf)
      `CHK("su on", 1'b0, on[2])
      `CHK("state", 2'(glfh_pkg::GLFH_ACTIVE), st)
      `CHK("count", exp_cnt, cnt)
      `CHK("irq", 1'b1, irq_n)
      @(posedge mclk_in);
      su_rst <= 1'b1;
      uv <= 3'h4;
      look(3);
      `CHK("state", 2'(glfh_pkg::GLFH_RESET), st)
      @(posedge mclk_in);
      uv <= 3'h0;
      su_rst <= 1'b0;
      loss(3'h0);
      strobe(6'h01);
      strobe(6'h04);
      `CHK("su en", 1'b1, su_en)
      // Wide loss, safe path; its undervoltage then leads to RESET.
      loss(3'h1);
      exp_cnt++;
      `CHK("wide flag", 1'b1, wf)
      `CHK("on", 3'h0, on)
      `CHK("dis", 3'h0, dis)
      `CHK("enables", 2'h0, {su_en, lv_en})
      `CHK("state", 2'(glfh_pkg::GLFH_SAFE), st)
      `CHK("count", exp_cnt, cnt)
      `CHK("irq", 1'b0, irq_n)
      @(posedge mclk_in);
      wu_rst <= 1'b1;
      uv <= 3'h1;
      look(3);
      `CHK("state", 2'(glfh_pkg::GLFH_RESET), st)
      `CHK("wide on", 1'b0, on[0])
      @(posedge mclk_in);
      uv <= 3'h0;
      wu_rst <= 1'b0;
      loss(3'h0);
      `CHK("wide on", 1'b1, on[0])
      `CHK("state", 2'(glfh_pkg::GLFH_RESET), st)
      strobe(6'h08);
      `CHK("wide flag", 1'b0, wf)
      strobe(6'h01);
      strobe(6'h04);
      // Wide loss, off path; undervoltage cannot leave it, but reset or a new LV or safe-path wide loss can.
      @(posedge mclk_in);
      off_en <= 1'b1;
      loss(3'h1);
      `CHK("dis", 3'h7, dis)
      `CHK("on", 3'h0, on)
      `CHK("enables", 2'h0, {su_en, lv_en})
      `CHK("irq", 1'b1, irq_n)
      `CHK("state", 2'(glfh_pkg::GLFH_OFF), st)
      `CHK("latch", 1'b1, latch)
      `CHK("wide flag", 1'b1, wf)
      `CHK("count", exp_cnt, cnt)
      end_of_test;
   end
endmodule : tb_ground_loss_fault_handler
